// ==== lfwdt_map.vh ====
// register map, field layout and reset values of the low-frequency watchdog
`ifndef LFWDT_MAP_VH
`define LFWDT_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define LFWDT_CTRL_OFS      12'h000
`define LFWDT_RESTART_OFS   12'h004
`define LFWDT_STAT_OFS      12'h008
`define LFWDT_INTST_OFS     12'h00c
`define LFWDT_INTMSK_OFS    12'h010
`define LFWDT_CNT_OFS       12'h014

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define LFWDT_CTRL_EN_BIT   0
`define LFWDT_CTRL_LOCK_BIT 1
`define LFWDT_CTRL_INT_LSB  4
`define LFWDT_CTRL_INT_MSB  6
`define LFWDT_INT_W         3
`define LFWDT_INT_MAX       3'h7

// restart key written to the restart register
`define LFWDT_RESTART_KEY   32'h0000_00a5

// status / interrupt bits
`define LFWDT_EV_W          2
`define LFWDT_EV_LOCKREJ    0
`define LFWDT_EV_RESTART    1

// status register bits
`define LFWDT_STAT_PEND_BIT 0
`define LFWDT_STAT_REQ_BIT  1

// ------------------------------------------------------------
// counter sizing: interval n gives 2^(INT_BASE+n) ticks
// ------------------------------------------------------------
`define LFWDT_CNT_W         21
`define LFWDT_INT_BASE      5'h0e
`define LFWDT_OSC_KHZ       80

`endif

// ==== lfwdt_top.v ====
// low-frequency watchdog timer with apb register access
//
// Summary of operation
// R1 - counter overflow asserts an internal system reset request
// R2 - software must restart the watchdog before overflow every interval
// R3 - after reset: enabled, counting, longest interval selected
// R4 - software may disable the watchdog while unlocked
// R5 - lock keeps it enabled; settings frozen until next system reset
// R6 - overflow never drives the external reset pin, only internal reset
// R7 - software selects timeout interval, setting ticks before overflow
// R8 - counter advances on the 80 kHz low-frequency oscillator clock
// R9 - restart clears counter to zero, crossed safely into oscillator domain
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "lfwdt_map.vh"

module lfwdt_top (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pclk_en,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    // low-frequency oscillator
    input  wire        low_freq_osc,
    // system
    output reg         sys_reset_req,
    output wire        irq
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg                      en_ff;
    reg                      lock_ff;
    reg [`LFWDT_INT_W-1:0]   int_sel_ff;
    reg [`LFWDT_EV_W-1:0]    int_st_ff;
    reg [`LFWDT_EV_W-1:0]    int_msk_ff;
    reg                      rst_tgl_ff;
    reg                      osc_s1_ff;
    reg                      osc_s2_ff;
    reg                      osc_s3_ff;
    reg                      ack_s1_ff;
    reg                      ack_s2_ff;
    reg [`LFWDT_CNT_W-1:0]   cnt_ff;
    reg                      ack_tgl_ff;
    reg                      seen_tgl_ff;

    wire xfer    = psel & penable & pclk_en;
    wire wr_acc  = xfer & pwrite;
    wire rd_acc  = xfer & ~pwrite;
    wire osc_rise = osc_s2_ff & ~osc_s3_ff;
    wire unmapped;

    // decode used only for the pslverr error response
    function is_mapped;
        input [11:0] a;
        begin
            if (a == `LFWDT_CTRL_OFS)
                is_mapped = 1'b1;
            else if (a == `LFWDT_RESTART_OFS)
                is_mapped = 1'b1;
            else if (a == `LFWDT_STAT_OFS)
                is_mapped = 1'b1;
            else if (a == `LFWDT_INTST_OFS)
                is_mapped = 1'b1;
            else if (a == `LFWDT_INTMSK_OFS)
                is_mapped = 1'b1;
            else if (a == `LFWDT_CNT_OFS)
                is_mapped = 1'b1;
            else
                is_mapped = 1'b0;
        end
    endfunction

    assign unmapped = ~is_mapped(paddr);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & unmapped;

    // ------------------------------------------------------------
    // control register and restart
    // ------------------------------------------------------------
    wire wr_ctrl    = wr_acc & (paddr == `LFWDT_CTRL_OFS);
    wire wr_restart = wr_acc & (paddr == `LFWDT_RESTART_OFS)
                      & (pwdata == `LFWDT_RESTART_KEY);
    wire lock_rej   = wr_ctrl & lock_ff;
    wire restart_ev = wr_restart & en_ff;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_ff      <= 1'b1;                // R3
            lock_ff    <= 1'b0;
            int_sel_ff <= `LFWDT_INT_MAX;      // R3
            rst_tgl_ff <= 1'b0;
        end else if (pclk_en) begin
            if (wr_ctrl && !lock_ff) begin     // R5
                en_ff      <= pwdata[`LFWDT_CTRL_EN_BIT];  // R4
                int_sel_ff <= pwdata[`LFWDT_CTRL_INT_MSB:`LFWDT_CTRL_INT_LSB];  // R7
                // lock forces enabled on
                if (pwdata[`LFWDT_CTRL_LOCK_BIT]) begin
                    lock_ff <= 1'b1;           // R5
                    en_ff   <= 1'b1;           // R5
                end
            end
            if (wr_restart)
                rst_tgl_ff <= ~rst_tgl_ff;     // R9
        end
    end

    // ------------------------------------------------------------
    // interrupt status, mask
    // ------------------------------------------------------------
    wire [`LFWDT_EV_W-1:0] ev_set;
    assign ev_set = {restart_ev, lock_rej};
    wire rd_intst = rd_acc & (paddr == `LFWDT_INTST_OFS);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_st_ff  <= {`LFWDT_EV_W{1'b0}};
            int_msk_ff <= {`LFWDT_EV_W{1'b0}};
        end else if (pclk_en) begin
            // a new event wins over the read clear
            int_st_ff <= (rd_intst ? {`LFWDT_EV_W{1'b0}} : int_st_ff) | ev_set;
            if (wr_acc && paddr == `LFWDT_INTMSK_OFS)
                int_msk_ff <= pwdata[`LFWDT_EV_W-1:0];
        end
    end

    assign irq = |(int_st_ff & int_msk_ff);

    // ------------------------------------------------------------
    // oscillator sampling and restart acknowledge
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_ff <= 1'b0;
            osc_s2_ff <= 1'b0;
            osc_s3_ff <= 1'b0;
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
        end else if (pclk_en) begin
            osc_s1_ff <= low_freq_osc;         // R8
            osc_s2_ff <= osc_s1_ff;
            osc_s3_ff <= osc_s2_ff;
            ack_s1_ff <= ack_tgl_ff;
            ack_s2_ff <= ack_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // watchdog counter, advanced on oscillator edges
    // ------------------------------------------------------------
    wire [`LFWDT_CNT_W:0] cnt_inc = {1'b0, cnt_ff} + {{`LFWDT_CNT_W{1'b0}}, 1'b1};
    wire [4:0]            ovf_bit = `LFWDT_INT_BASE + {2'h0, int_sel_ff};
    wire                  restart_pend = (rst_tgl_ff != seen_tgl_ff);
    wire                  ovf_now = en_ff & osc_rise & cnt_inc[ovf_bit];
    wire                  restart_take = restart_pend & osc_rise;
    reg [`LFWDT_CNT_W-1:0] nxt_cnt;

    // restart beats disable, disable holds the count at zero
    always @* begin
        nxt_cnt = cnt_ff;
        if (restart_take) begin
            nxt_cnt = {`LFWDT_CNT_W{1'b0}};        // R9
        end else if (!en_ff) begin
            nxt_cnt = {`LFWDT_CNT_W{1'b0}};        // R4
        end else if (osc_rise) begin
            nxt_cnt = cnt_inc[`LFWDT_CNT_W-1:0];    // R8
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff        <= {`LFWDT_CNT_W{1'b0}};
            seen_tgl_ff   <= 1'b0;
            ack_tgl_ff    <= 1'b0;
            sys_reset_req <= 1'b0;
        end else if (pclk_en) begin
            cnt_ff <= nxt_cnt;
            if (restart_take) begin
                seen_tgl_ff <= rst_tgl_ff;            // R9
                ack_tgl_ff  <= rst_tgl_ff;
            end
            // internal reset only; no external pin is driven
            if (ovf_now && !restart_pend)
                sys_reset_req <= 1'b1;                 // R1 R6
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    reg [31:0] nxt_prdata;
    wire       rd_setup = pclk_en & psel & ~penable & ~pwrite;

    // unmapped and write-only offsets read as zero
    always @* begin
        nxt_prdata = 32'h0000_0000;
        if (paddr == `LFWDT_CTRL_OFS) begin
            nxt_prdata[`LFWDT_CTRL_EN_BIT]   = en_ff;
            nxt_prdata[`LFWDT_CTRL_LOCK_BIT] = lock_ff;
            nxt_prdata[`LFWDT_CTRL_INT_MSB:`LFWDT_CTRL_INT_LSB] = int_sel_ff;
        end else if (paddr == `LFWDT_STAT_OFS) begin
            nxt_prdata[`LFWDT_STAT_PEND_BIT] = restart_pend | (ack_s2_ff != rst_tgl_ff);
            nxt_prdata[`LFWDT_STAT_REQ_BIT]  = sys_reset_req;
        end else if (paddr == `LFWDT_INTST_OFS) begin
            nxt_prdata[`LFWDT_EV_W-1:0] = int_st_ff;
        end else if (paddr == `LFWDT_INTMSK_OFS) begin
            nxt_prdata[`LFWDT_EV_W-1:0] = int_msk_ff;
        end else if (paddr == `LFWDT_CNT_OFS) begin
            nxt_prdata[`LFWDT_CNT_W-1:0] = cnt_ff;
        end
    end

    // captured in the setup cycle, stands through the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= nxt_prdata;
        end
    end

endmodule
`default_nettype wire

// ==== lfwdt_top_chk.sv ====
// port checker for the low-frequency watchdog
`timescale 1ns/1ps
`default_nettype none
`include "lfwdt_map.vh"
module lfwdt_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        low_freq_osc,
    input wire logic        sys_reset_req
);
    logic lock_ff;
    logic wr_ff;
    wire  ctl    = psel && penable && paddr == `LFWDT_CTRL_OFS;
    wire  ctl_rd = ctl && !pwrite;
    // lock as seen on the bus, by write or by read back
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_ff <= 1'b0;
            wr_ff   <= 1'b0;
        end else begin
            lock_ff <= lock_ff | (ctl & (pwrite ? pwdata[1] : prdata[1]));
            wr_ff   <= wr_ff | (ctl & pwrite);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence off_then_rd;
        ctl && pwrite && pwdata[1:0] == 2'h0 && !lock_ff ##3 ctl_rd;
    endsequence
    a_req_held: assert property (sys_reset_req |=> sys_reset_req)
        else $error("reset request dropped");
    a_req_quiet: assert property ($rose(presetn) |-> !sys_reset_req [*8])
        else $error("request right after reset");
    a_ctrl_dflt: assert property (ctl_rd && !wr_ff |-> prdata[6:0] == 7'h71)
        else $error("control default wrong");
    a_off_takes: assert property (off_then_rd |-> !prdata[0])
        else $error("disable ignored");
    a_lock_holds: assert property (ctl_rd && lock_ff |-> prdata[1:0] == 2'h3)
        else $error("lock lost");
    a_lock_en: assert property (ctl_rd && prdata[1] |-> prdata[0])
        else $error("locked but disabled");
    a_osc_paced: assert property ($stable(low_freq_osc) [*8] |-> !$rose(sys_reset_req))
        else $error("overflow without oscillator");
    a_slv_err: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
        else $error("unmapped without error");
endmodule
bind lfwdt_top lfwdt_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .low_freq_osc(low_freq_osc), .sys_reset_req(sys_reset_req));
`default_nettype wire

// ==== tb_lfwdt_top.sv ====
// self-checking testbench for the low-frequency watchdog
`timescale 1ns/1ps
`default_nettype none
`include "lfwdt_map.vh"
module tb_lfwdt_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        low_freq_osc = 1'b0, osc_run = 1'b0, err, pclk_en = 1'b1;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    wire         pready, pslverr, sys_reset_req, irq;
    wire  [31:0] prdata;
    int          failures = 0, checked = 0, cycles = 0, n;
    lfwdt_top dut (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .low_freq_osc(low_freq_osc),
        .sys_reset_req(sys_reset_req), .irq(irq));
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (osc_run)
            low_freq_osc <= ~low_freq_osc;
        if (cycles == 60000) begin
            failures++;
            final_report();
        end
    end
    task automatic chk(input logic [31:0] seen, exp, input string what);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, what);
    endtask
    task automatic t_reset;
        repeat (20) @(posedge pclk);
        rchk(`LFWDT_CTRL_OFS, 32'h71, "ctrl");
        pclk_en <= 1'b0;
        apb(1'b1, `LFWDT_CTRL_OFS, 32'h1);
        pclk_en <= 1'b1;
        rchk(`LFWDT_CTRL_OFS, 32'h71, "ctrl frozen");
        rchk(`LFWDT_CNT_OFS, 32'h0, "count still");
        rchk(12'h020, 32'h0, "unmapped");
        chk({31'h0, err}, 32'h1, "slverr");
        $display("reset done");
    endtask
    task automatic t_disable;
        apb(1'b1, `LFWDT_CTRL_OFS, 32'h0);
        rchk(`LFWDT_CTRL_OFS, 32'h0, "ctrl off");
        osc_run <= 1'b1;
        repeat (64) @(posedge pclk);
        rchk(`LFWDT_CNT_OFS, 32'h0, "count off");
        $display("disable done");
    endtask
    task automatic t_lock;
        apb(1'b1, `LFWDT_CTRL_OFS, 32'h2);
        apb(1'b1, `LFWDT_CTRL_OFS, 32'h70);
        rchk(`LFWDT_CTRL_OFS, 32'h3, "ctrl locked");
        chk({31'h0, irq}, 32'h0, "irq masked");
        apb(1'b1, `LFWDT_INTMSK_OFS, 32'h1);
        chk({31'h0, irq}, 32'h1, "irq set");
        rchk(`LFWDT_INTST_OFS, 32'h1, "int status");
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("lock done");
    endtask
    task automatic t_overflow;
        repeat (2000) @(posedge pclk);
        apb(1'b1, `LFWDT_RESTART_OFS, `LFWDT_RESTART_KEY);
        repeat (8) @(posedge pclk);
        apb(1'b0, `LFWDT_CNT_OFS, 32'h0);
        chk({3'h0, rd[31:3]}, 32'h0, "count restarted");
        n = 0;
        while (sys_reset_req !== 1'b1 && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        chk({31'h0, n > 32700 && n < 32800}, 32'h1, "overflow time");
        rchk(`LFWDT_STAT_OFS, 32'h2, "status");
        rchk(`LFWDT_INTST_OFS, 32'h2, "restart event");
        $display("overflow done");
    endtask
    task automatic t_rereset;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk({31'h0, sys_reset_req}, 32'h0, "request");
        rchk(`LFWDT_CTRL_OFS, 32'h71, "ctrl again");
        $display("rereset done");
    endtask
    task automatic final_report;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_disable();
        t_lock();
        t_overflow();
        t_rereset();
        final_report();
    end
endmodule
`default_nettype wire
